//--- sim/sdtic_ctrl_model.sv
// controller-side model: power-up order and legal command spacing toward the core
`timescale 1ns/1ps
`default_nettype none
module sdtic_ctrl_model
    import sdtic_pkg::*;
#(
    parameter int GRADE  = 0,
    parameter int PWR_UP = 2500
) (
    input  wire logic        clk,
    output logic             cke,
    output sdtic_cmd_s       cmd,
    output logic [DQM_W-1:0] dqm,
    output logic [DQ_W-1:0]  dq_in
);
    int cyc = 0;
    int cl  = 2;
    int bl  = 1;
    int t_act[BANKS] = '{default: -99};
    int t_pre[BANKS] = '{default: -99};
    int t_wr[BANKS]  = '{default: -99};
    int t_any = -99;
    int t_ref = -99;
    int t_lmr = -99;

    initial begin
        cke   = 1'b1;
        dqm   = '1;
        dq_in = '0;
        cmd   = '1;
    end

    always @(posedge clk) cyc++;

    ////////////////////////////////////////////////////////////////
    function automatic int mx(input int x, input int y);
        return (x > y) ? x : y;
    endfunction

    // row timings follow programmed latency and speed grade
    function automatic int row_cycle_period();
        return (cl == 3) ? 11 - GRADE : ((GRADE == 2) ? 8 : 6);
    endfunction

    function automatic int tras();
        return (cl == 3) ? 8 - GRADE : ((GRADE == 0) ? 4 : 5);
    endfunction

    // released data lines flip every cycle so stale values never look valid
    task automatic data(input logic [DQ_W-1:0] d, input logic [DQM_W-1:0] m);
        @(negedge clk);
        cmd   = '1;
        dq_in = d;
        dqm   = m;
    endtask

    task automatic idle(input int n);
        repeat (n) data(~dq_in, '0);
    endtask

    // waits out the tracked minimum spacings before putting the command on the bus; refresh does not wait out the precharge spacing
    task automatic drive(input logic [2:0] op, input logic [1:0] ba, input logic [11:0] a,
                         input logic [DQ_W-1:0] d = '0, input logic cs = 1'b0);
        int b;
        int need;
        b    = int'(ba);
        need = t_lmr + 2;
        case (op)
            CMD_ACT: need = mx(mx(need, t_act[b] + row_cycle_period()), mx(t_pre[b] + cl, t_any + 2));
            CMD_RD, CMD_WR: need = mx(need, t_act[b] + cl);
            CMD_PRE: for (int i = 0; i < BANKS; i++)
                if (a[10] || i == b) need = mx(need, mx(t_act[i] + tras(), t_wr[i] + 2));
            default: ;
        endcase
        if (op == CMD_ACT || op == CMD_REF)
            need = mx(mx(need, t_ref + row_cycle_period()), t_wr[b] + cl + 2);
        data(~dq_in, '0);
        while (cyc + 1 < need)
            data(~dq_in, '0);
        cmd   = '{cs, op[2], op[1], op[0], ba[1], ba[0], a};
        dq_in = d;
        if (!cs) begin
            case (op)
                CMD_ACT: t_act[b] = cyc + 1;
                CMD_PRE: for (int i = 0; i < BANKS; i++)
                    if (a[10] || i == b) t_pre[i] = cyc + 1;
                CMD_WR:  t_wr[b] = cyc + bl;
                CMD_REF: t_ref = cyc + 1;
                CMD_LMR: begin
                    t_lmr = cyc + 1;
                    cl    = (a[6:4] == CL_3) ? 3 : 2;
                    bl    = a[9] ? 1 : 1 << a[1:0];
                end
                default: ;
            endcase
            if (op == CMD_ACT) t_any = cyc + 1;
        end
    endtask

    task automatic init(input logic [MODE_W-1:0] mode);
        repeat (PWR_UP) @(negedge clk);
        drive(CMD_PRE, 2'h0, 12'h400);
        drive(CMD_REF, 2'h0, 12'h000);
        drive(CMD_REF, 2'h0, 12'h000);
        drive(CMD_LMR, 2'h0, mode);
        idle(2);
    endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
// testbench: sdram core driven by the controller model, write buffer seen through the core
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sdtic_pkg::*;
    logic             clk = 1'b0;
    logic             reset = 1'b1;
    logic             cke;
    sdtic_cmd_s       cmd;
    logic [DQM_W-1:0] dqm;
    logic [DQ_W-1:0]  dq_in;
    logic [DQ_W-1:0]  dq_out;
    logic [DQM_W-1:0] dq_oe_n;
    logic             wr_buf_ready;
    logic [BANKS-1:0] bank_open;
    int               errors = 0;
    int               n_tests = 0;

    initial forever #20 clk = ~clk;

    sdtic_core u_sdtic_core (.clk, .reset, .cke, .cmd, .dqm, .dq_in, .dq_out, .dq_oe_n,
                             .wr_buf_ready, .bank_open);
    sdtic_ctrl_model #(.GRADE(0), .PWR_UP(2500)) u_ctl (.clk, .cke, .cmd, .dqm, .dq_in);

    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // state right after reset: buffer empty and ready, no row open, outputs floating
    task automatic t_reset();
        @(negedge clk);
        check("reset buffer ready", wr_buf_ready, 1'b1);
        check("reset banks closed", bank_open, 4'h0);
        check("reset outputs float", dq_oe_n, 2'h3);
        $display("t_reset done");
    endtask

    task automatic t_act();
        u_ctl.drive(CMD_ACT, 2'h0, 12'h005);
        u_ctl.drive(CMD_ACT, 2'h3, 12'hfff);
        u_ctl.idle(1);
        check("open banks", bank_open, 4'h9);
        u_ctl.drive(CMD_ACT, 2'h2, 12'h001, '0, 1'b1);
        u_ctl.idle(1);
        check("open deselected", bank_open, 4'h9);
        check("buffer ready", wr_buf_ready, 1'b1);
        $display("t_act done");
    endtask

    task automatic t_wr_rd();
        u_ctl.idle(4);
        u_ctl.drive(CMD_WR, 2'h0, 12'h004, 16'h1234);
        u_ctl.data(16'h5678, 2'h0);
        u_ctl.drive(CMD_WR, 2'h3, 12'h1ff, 16'hbeef);
        u_ctl.data(16'hcafe, 2'h0);
        u_ctl.idle(12);
        u_ctl.drive(CMD_RD, 2'h0, 12'h004);
        u_ctl.drive(CMD_RD, 2'h3, 12'h1ff);
        u_ctl.data(16'h0000, 2'h2);
        check("read first", {dq_oe_n, dq_out}, {2'h0, 16'h1234});
        u_ctl.idle(1);
        check("read back to back", {dq_oe_n, dq_out}, {2'h0, 16'hbeef});
        u_ctl.idle(1);
        check("read masked", {dq_oe_n, dq_out[7:0]}, {2'h2, 8'hfe});
        u_ctl.idle(1);
        check("read end", dq_oe_n, 2'h3);
        $display("t_wr_rd done");
    endtask

    task automatic t_stop();
        u_ctl.drive(CMD_PRE, 2'h0, 12'h400);
        u_ctl.drive(CMD_LMR, 2'h0, 12'h033);
        u_ctl.drive(CMD_ACT, 2'h0, 12'h005);
        u_ctl.drive(CMD_WR, 2'h0, 12'h008, 16'haaa0);
        u_ctl.data(16'haaa1, 2'h0);
        u_ctl.drive(CMD_BST, 2'h0, 12'h000, 16'haaa2);
        u_ctl.idle(12);
        u_ctl.drive(CMD_RD, 2'h0, 12'h008);
        u_ctl.drive(CMD_BST, 2'h0, 12'h000);
        u_ctl.idle(2);
        check("stop word", {dq_oe_n, dq_out}, {2'h0, 16'haaa0});
        u_ctl.idle(1);
        check("stop float", dq_oe_n, 2'h3);
        u_ctl.drive(CMD_RD, 2'h0, 12'h008);
        u_ctl.idle(1);
        u_ctl.drive(CMD_PRE, 2'h0, 12'h000);
        u_ctl.idle(2);
        check("pre word", dq_out, 16'haaa1);
        u_ctl.idle(1);
        check("pre float", dq_oe_n, 2'h3);
        u_ctl.drive(CMD_ACT, 2'h0, 12'h005);
        u_ctl.drive(CMD_RD, 2'h0, 12'h408);
        for (int k = 1; k <= 9; k++) begin
            u_ctl.idle(1);
            if (k == 5) check("write after stop", dq_out === 16'haaa2, 1'b0);
            if (k >= 8) check("auto close", bank_open[0], k == 8);
        end
        u_ctl.idle(4);
        $display("t_stop done");
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        print_verdict();
    end

    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        t_reset();
        u_ctl.init(12'h021);
        t_act();
        t_wr_rd();
        t_stop();
        print_verdict();
    end
endmodule
`default_nettype wire

//--- src/sdtic_core.sv
// four-bank synchronous dram core: command decode, bursts, masks, output timing
//
// Overview of operation
// - everything sampled on rising clock edge only
// - four banks, 4096 rows, 512x16
// - activate picks bank/row, column from low address
// - new column command accepted every cycle
// - burst stop floats read data after latency
// - burst stop drops write data same cycle
// - precharge floats read data after latency
// - precharge drops write data same cycle
// - read auto-precharge starts latency-1 before end
// - mask blanks reads two later, writes now
// - chip select high means no operation
// - mode register field layout
// - read data valid at edge n plus latency
`timescale 1ns/1ps
`default_nettype none
module sdtic_core
    import sdtic_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              cke,
    input  wire sdtic_cmd_s        cmd,
    input  wire logic [DQM_W-1:0]  dqm,
    input  wire logic [DQ_W-1:0]   dq_in,
    output logic [DQ_W-1:0]        dq_out,
    output logic [DQM_W-1:0]       dq_oe_n,
    output logic                   wr_buf_ready,
    output logic [BANKS-1:0]       bank_open
);
    sdtic_state_s      st_q;
    sdtic_state_s      st_d;
    logic [DQ_W-1:0]   mem [0:(2**MA_W)-1];
    logic              live;
    logic [2:0]        code;
    logic [BANK_W-1:0] cbank;
    logic              cmd_rd;
    logic              cmd_wr;
    logic              cmd_bst;
    logic              cmd_pre;
    logic              cmd_act;
    logic              cmd_lmr;
    logic              cl3;
    logic              seq;
    logic              fetch_v;
    logic              pre_hit;
    logic              last;
    logic [COL_W:0]    len;
    logic [COL_W:0]    wlen;
    logic [COL_W-1:0]  msk;
    logic [COL_W-1:0]  col_now;
    logic [DQ_W-1:0]   rd_word;
    logic              push;
    sdtic_wr_s         push_w;
    logic              pop_v;
    sdtic_wr_s         pop_w;

    function automatic logic [COL_W:0] blen_of(input logic [MODE_W-1:0] m, input logic wr);
        logic [COL_W:0] n;
        case (m[BL_LSB+:BL_W])
            BL_2:    n = (COL_W+1)'(2);
            BL_4:    n = (COL_W+1)'(4);
            BL_8:    n = (COL_W+1)'(8);
            BL_PAGE: n = (COL_W+1)'(2**COL_W);
            default: n = (COL_W+1)'(1);
        endcase
        if (wr && m[WBM_BIT]) begin
            n = (COL_W+1)'(1);
        end
        return n;
    endfunction

    //////////////////////////////////////////////////////////////////////////////////////////
    // command decode
    assign live    = cke && !cmd.cs_n;
    assign code    = {cmd.ras_n, cmd.cas_n, cmd.we_n};
    assign cbank   = {cmd.bank_sel_bit1, cmd.bank_sel_bit0};
    assign cmd_rd  = live && code == CMD_RD;
    assign cmd_wr  = live && code == CMD_WR;
    assign cmd_bst = live && code == CMD_BST;
    assign cmd_pre = live && code == CMD_PRE;
    assign cmd_act = live && code == CMD_ACT;
    assign cmd_lmr = live && code == CMD_LMR;
    assign cl3     = st_q.mode[CL_LSB+:CL_W] == CL_3;
    assign seq     = !st_q.mode[BT_BIT];

    // burst address walk inside the block chosen by burst length
    assign len     = blen_of(st_q.mode, st_q.wr_act);
    assign wlen    = blen_of(st_q.mode, 1'b1);
    assign msk     = COL_W'(len - 1'b1);
    assign col_now = seq ? ((st_q.start & ~msk) | (COL_W'(st_q.start + st_q.cnt) & msk))
                         : (st_q.start ^ (st_q.cnt & msk));
    assign last    = (st_q.cnt == msk) && (st_q.mode[BL_LSB+:BL_W] != BL_PAGE);
    assign fetch_v = cke && st_q.rd_act;
    assign pre_hit = cmd_pre && (cmd.addr[AP_BIT] || cbank == st_q.bank);
    assign rd_word = mem[{st_q.bank, st_q.rows[st_q.bank], col_now}];

    //////////////////////////////////////////////////////////////////////////////////////////
    // next state; cke low freezes the core state like a stopped clock, while the write buffer keeps draining into the array
    always_comb begin
        st_d   = st_q;
        push   = 1'b0;
        push_w = '0;
        if (cke) begin
            st_d.dqm_q    = dqm;
            st_d.p1_valid = fetch_v;
            st_d.p1_data  = rd_word;
            st_d.out_valid = (cl3 ? st_q.p1_valid : fetch_v) ? ~st_q.dqm_q : '0;
            st_d.out_data  = cl3 ? st_q.p1_data : rd_word;
            if (st_q.rd_act || st_q.wr_act) begin
                st_d.cnt = st_q.cnt + 1'b1;
                if (last) begin
                    st_d.rd_act = 1'b0;
                    st_d.wr_act = 1'b0;
                    if (st_q.ap) begin
                        // last fetch edge is latency-1 ahead of last word out
                        st_d.open[st_q.bank] = 1'b0;
                    end
                end
                if (st_q.wr_act && !cmd_bst && !pre_hit && !cmd_rd && !cmd_wr) begin
                    push   = |(~dqm);
                    push_w = '{addr: {st_q.bank, st_q.rows[st_q.bank], col_now},
                               be: ~dqm, data: dq_in};
                end
            end
            if (cmd_bst || pre_hit) begin
                st_d.rd_act = 1'b0;
                st_d.wr_act = 1'b0;
            end
            if (cmd_pre) begin
                for (int b = 0; b < BANKS; b++) begin
                    if (cmd.addr[AP_BIT] || cbank == BANK_W'(b)) begin
                        st_d.open[b] = 1'b0;
                    end
                end
            end
            if (cmd_act) begin
                st_d.open[cbank] = 1'b1;
                st_d.rows[cbank] = cmd.addr[ROW_W-1:0];
            end
            if (cmd_lmr) begin
                st_d.mode = cmd.addr;
            end
            if (cmd_rd || cmd_wr) begin
                st_d.start  = cmd.addr[COL_W-1:0];
                st_d.cnt    = '0;
                st_d.bank   = cbank;
                st_d.ap     = cmd.addr[AP_BIT];
                st_d.rd_act = cmd_rd;
                st_d.wr_act = cmd_wr;
                if (cmd_wr) begin
                    push   = |(~dqm);
                    push_w = '{addr: {cbank, st_q.rows[cbank], cmd.addr[COL_W-1:0]},
                               be: ~dqm, data: dq_in};
                    st_d.cnt = COL_W'(1);
                    if (wlen == (COL_W+1)'(1)) begin
                        st_d.wr_act = 1'b0;
                        if (cmd.addr[AP_BIT]) begin
                            st_d.open[cbank] = 1'b0;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q      <= '0;
            st_q.mode <= MODE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // write buffer drains into the array whenever no read fetch needs it
    sdtic_fifo #(
        .W     ($bits(sdtic_wr_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_wbuf (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (push),
        .in_ready  (wr_buf_ready),
        .in_data   (push_w),
        .out_valid (pop_v),
        .out_ready (!fetch_v),
        .out_data  (pop_w)
    );

    for (genvar i = 0; i < DQM_W; i++) begin : g_lane
        always_ff @(posedge clk) begin
            if (pop_v && !fetch_v && pop_w.be[i]) begin
                mem[pop_w.addr][8*i+:8] <= pop_w.data[8*i+:8];
            end
        end
    end

    assign dq_out    = st_q.out_data;
    assign dq_oe_n   = ~st_q.out_valid;
    assign bank_open = st_q.open;

    //////////////////////////////////////////////////////////////////////////////////////////
    // checks
    nop_cs_a: assert property (@(posedge clk) disable iff (reset)
        (cmd.cs_n && !st_q.rd_act && !st_q.wr_act) |=> (st_q.open == $past(st_q.open))
        && (st_q.mode == $past(st_q.mode)))
        else $error("chip select high changed state");

    rd_cl2_a: assert property (@(posedge clk) disable iff (reset)
        (cmd_rd && !cl3 && !dqm[0]) ##1 cke |=> !dq_oe_n[0])
        else $error("latency two read data missing");

    rd_cl3_a: assert property (@(posedge clk) disable iff (reset)
        (cmd_rd && cl3) ##1 (cke && !dqm[0]) ##1 cke |=> !dq_oe_n[0])
        else $error("latency three read data missing");

    dqm_rd_a: assert property (@(posedge clk) disable iff (reset)
        (cke && dqm[0]) ##1 cke |=> dq_oe_n[0])
        else $error("read mask did not blank data");

    stop_hiz_a: assert property (@(posedge clk) disable iff (reset)
        (cmd_bst && cl3) ##1 cke [*2] |=> &dq_oe_n)
        else $error("outputs driven after burst stop");

    pre_hiz_a: assert property (@(posedge clk) disable iff (reset)
        (cmd_pre && cmd.addr[AP_BIT] && !cl3) ##1 cke |=> &dq_oe_n)
        else $error("outputs driven after precharge");

    wr_stop_a: assert property (@(posedge clk) disable iff (reset)
        (cmd_bst || pre_hit) |-> !push)
        else $error("write data taken on stop or precharge");

    wr_mask_a: assert property (@(posedge clk) disable iff (reset)
        push |-> (push_w.be == ~dqm) && (push_w.data == dq_in))
        else $error("write mask not applied in same cycle");

    ap_close_a: assert property (@(posedge clk) disable iff (reset)
        (fetch_v && last && st_q.ap && !live) |=> !st_q.open[$past(st_q.bank)])
        else $error("auto precharge did not start");

    act_open_a: assert property (@(posedge clk) disable iff (reset)
        cmd_act |=> st_q.open[$past(cbank)]
        && (st_q.rows[$past(cbank)] == $past(cmd.addr[ROW_W-1:0])))
        else $error("activate did not open row");

    mode_load_a: assert property (@(posedge clk) disable iff (reset)
        cmd_lmr |=> st_q.mode == $past(cmd.addr))
        else $error("mode register not loaded");
endmodule
`default_nettype wire

//--- src/sdtic_fifo.sv
// write-data buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sdtic_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } sdtic_fptr_s;

    sdtic_fptr_s   st_q;
    sdtic_fptr_s   st_d;
    logic [W-1:0]  mem [0:DEPTH-1];
    logic          do_push;
    logic          do_pop;

    assign out_valid = st_q.wp != st_q.rp;
    assign in_ready  = st_q.wp != {~st_q.rp[AW], st_q.rp[AW-1:0]};
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;
    assign out_data  = mem[st_q.rp[AW-1:0]];

    always_comb begin
        st_d = st_q;
        if (do_push) begin
            st_d.wp = st_q.wp + 1'b1;
        end
        if (do_pop) begin
            st_d.rp = st_q.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[st_q.wp[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

//--- src/sdtic_pkg.sv
// shared constants, command codes and carrier types of the sdram timing core
package sdtic_pkg;
    localparam int ROW_W  = 12;
    localparam int COL_W  = 9;
    localparam int DQ_W   = 16;
    localparam int DQM_W  = DQ_W / 8;
    localparam int BANKS  = 4;
    localparam int BANK_W = 2;
    localparam int MA_W   = BANK_W + ROW_W + COL_W;
    localparam int MODE_W = 12;
    localparam int FIFO_DEPTH = 8;

    // mode register layout
    localparam int BL_LSB  = 0;
    localparam int BL_W    = 3;
    localparam int BT_BIT  = 3;
    localparam int CL_LSB  = 4;
    localparam int CL_W    = 3;
    localparam int WBM_BIT = 9;
    localparam int AP_BIT  = 10;
    localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;

    localparam logic [BL_W-1:0] BL_1    = 3'h0;
    localparam logic [BL_W-1:0] BL_2    = 3'h1;
    localparam logic [BL_W-1:0] BL_4    = 3'h2;
    localparam logic [BL_W-1:0] BL_8    = 3'h3;
    localparam logic [BL_W-1:0] BL_PAGE = 3'h7;
    localparam logic [CL_W-1:0] CL_2    = 3'h2;
    localparam logic [CL_W-1:0] CL_3    = 3'h3;

    // device-side delays in cycles
    localparam int MASK_RD_DLY = 2;
    localparam int HIZ_DLY_CL3 = 3;
    localparam int HIZ_DLY_CL2 = 2;

    // {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_LMR = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic              bank_sel_bit1;
        logic              bank_sel_bit0;
        logic [MODE_W-1:0] addr;
    } sdtic_cmd_s;

    typedef struct packed {
        logic [MA_W-1:0]  addr;
        logic [DQM_W-1:0] be;
        logic [DQ_W-1:0]  data;
    } sdtic_wr_s;

    typedef struct packed {
        logic [MODE_W-1:0]            mode;
        logic [BANKS-1:0]             open;
        logic [BANKS-1:0][ROW_W-1:0]  rows;
        logic                         rd_act;
        logic                         wr_act;
        logic                         ap;
        logic [BANK_W-1:0]            bank;
        logic [COL_W-1:0]             start;
        logic [COL_W-1:0]             cnt;
        logic [DQM_W-1:0]             dqm_q;
        logic                         p1_valid;
        logic [DQ_W-1:0]              p1_data;
        logic [DQM_W-1:0]             out_valid;
        logic [DQ_W-1:0]              out_data;
    } sdtic_state_s;
endpackage
